// [design/fcs_pkg.sv]
package fcs_pkg;
  // Clock and timing
  localparam longint CLK_HZ          = 25_000_000;
  localparam longint US_PER_S        = 1_000_000;
  localparam longint NS_PER_S        = 1_000_000_000;
  localparam longint T_WAIT_LONG_US  = 200;
  localparam longint T_WAIT_SHORT_US = 50;
  localparam longint T_READY_MAX_US  = 200;
  localparam longint T_READY_LOW_NS  = 70;
  localparam longint T_DONE_LOW_NS   = 80;
  localparam int CNT_W = 24;
  // Least times round up
  localparam int WAIT_LONG_CYC  = int'((T_WAIT_LONG_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
  localparam int WAIT_SHORT_CYC = int'((T_WAIT_SHORT_US * CLK_HZ + US_PER_S - 1) / US_PER_S);
  // Longest times round down; the ns times never below one cycle
  localparam int READY_MAX_CYC  = int'((T_READY_MAX_US * CLK_HZ) / US_PER_S);
  localparam int READY_LOW_CYC  = (int'((T_READY_LOW_NS * CLK_HZ) / NS_PER_S) < 1) ? 1 :
                                  int'((T_READY_LOW_NS * CLK_HZ) / NS_PER_S);
  localparam int DONE_LOW_CYC   = (int'((T_DONE_LOW_NS * CLK_HZ) / NS_PER_S) < 1) ? 1 :
                                  int'((T_DONE_LOW_NS * CLK_HZ) / NS_PER_S);
  localparam logic [CNT_W-1:0] WAKE_CYC = 24'h000008;

  // Identity (value arbitrary)
  localparam logic [31:0] DEVICE_IDENTIFIER = 32'h5A3C_0001;

  // Image layout: 4 id bytes MSB first, flag byte, body, xor checksum byte
  localparam logic [1:0] ID_LAST_BYTE = 2'h3;
  localparam int         SECURE_BIT   = 0;

  // Host command codes
  localparam logic [2:0] OP_RD_ID     = 3'h0;
  localparam logic [2:0] OP_RD_USER   = 3'h1;
  localparam logic [2:0] OP_RD_STATUS = 3'h2;
  localparam logic [2:0] OP_READBACK  = 3'h3;
  localparam logic [2:0] OP_LOAD      = 3'h4;

  // Status word fields
  localparam int ST_READY    = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_USER     = 2;
  localparam int ST_ID_FAIL  = 3;
  localparam int ST_CHK_FAIL = 4;
  localparam int ST_SECURE   = 5;
  localparam int ST_JTAG     = 6;
  localparam int ST_BUSY     = 7;
  localparam int ST_MODE_LSB = 8;

  typedef enum logic [2:0] {
    FCS_OFF, FCS_INIT, FCS_SAMPLE, FCS_LOAD, FCS_WAKE, FCS_USER, FCS_FAIL
  } fcs_state_e;

  typedef enum logic [2:0] {
    FCS_L_IDLE, FCS_L_ID, FCS_L_FLAGS, FCS_L_BODY
  } fcs_lstate_e;
endpackage

// [design/fcs_ld_if.sv]
`timescale 1ns/1ps
interface fcs_ld_if;
  logic       start;
  logic       abort;
  logic       busy;
  logic       done;
  logic       id_ok;
  logic       chk_ok;
  logic       secure;
  logic [7:0] chk_val;
  modport seq (output start, output abort,
               input busy, input done, input id_ok, input chk_ok, input secure, input chk_val);
  modport ld  (input start, input abort,
               output busy, output done, output id_ok, output chk_ok, output secure,
               output chk_val);
endinterface

// [design/fcs_loader.sv]
`timescale 1ns/1ps
module fcs_loader (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Sequencer side
  fcs_ld_if.ld            lk,
  // Configuration byte stream
  input  wire logic [7:0] cfg_data,
  input  wire logic       cfg_valid,
  input  wire logic       cfg_last,
  output logic            cfg_ready
);
  import fcs_pkg::*;

  fcs_lstate_e st_q;
  logic [1:0]  idx_q;
  logic        id_match_q;
  logic [7:0]  xor_q;
  logic        take;

  function automatic logic [7:0] id_byte(input logic [1:0] i);
    id_byte = DEVICE_IDENTIFIER[8'(31 - 8 * i) -: 8];
  endfunction

  assign take = cfg_valid && cfg_ready;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q       <= FCS_L_IDLE;
      idx_q      <= 2'h0;
      id_match_q <= 1'b0;
      xor_q      <= 8'h00;
      cfg_ready  <= 1'b0;
      lk.busy    <= 1'b0;
      lk.done    <= 1'b0;
      lk.id_ok   <= 1'b0;
      lk.chk_ok  <= 1'b0;
      lk.secure  <= 1'b0;
      lk.chk_val <= 8'h00;
    end else begin
      lk.done <= 1'b0;
      if (lk.abort) begin
        st_q      <= FCS_L_IDLE;
        cfg_ready <= 1'b0;
        lk.busy   <= 1'b0;
      end else begin
        case (st_q)
          FCS_L_IDLE: begin
            if (lk.start) begin
              st_q       <= FCS_L_ID;
              idx_q      <= 2'h0;
              id_match_q <= 1'b1;
              xor_q      <= 8'h00;
              cfg_ready  <= 1'b1;
              lk.busy    <= 1'b1;
              lk.id_ok   <= 1'b0;
              lk.chk_ok  <= 1'b0;
              lk.secure  <= 1'b0;
            end
          end
          FCS_L_ID: begin
            if (take) begin
              xor_q <= xor_q ^ cfg_data;
              idx_q <= idx_q + 2'h1;
              // Identifier checked before any body byte is accepted
              if (idx_q == ID_LAST_BYTE || cfg_last) begin
                if (id_match_q && cfg_data == id_byte(idx_q) && !cfg_last) begin
                  lk.id_ok <= 1'b1;
                  st_q     <= FCS_L_FLAGS;
                end else begin
                  st_q      <= FCS_L_IDLE;
                  cfg_ready <= 1'b0;
                  lk.busy   <= 1'b0;
                  lk.done   <= 1'b1;
                end
              end else if (cfg_data != id_byte(idx_q)) begin
                id_match_q <= 1'b0;
              end
            end
          end
          FCS_L_FLAGS: begin
            if (take) begin
              xor_q     <= xor_q ^ cfg_data;
              lk.secure <= cfg_data[SECURE_BIT];
              if (cfg_last) begin
                st_q      <= FCS_L_IDLE;
                cfg_ready <= 1'b0;
                lk.busy   <= 1'b0;
                lk.done   <= 1'b1;
              end else begin
                st_q <= FCS_L_BODY;
              end
            end
          end
          FCS_L_BODY: begin
            if (take) begin
              if (cfg_last) begin
                // Data check result
                lk.chk_ok  <= (xor_q == cfg_data);
                lk.chk_val <= xor_q;
                st_q       <= FCS_L_IDLE;
                cfg_ready  <= 1'b0;
                lk.busy    <= 1'b0;
                lk.done    <= 1'b1;
              end else begin
                xor_q <= xor_q ^ cfg_data;
              end
            end
          end
          default: st_q <= FCS_L_IDLE;
        endcase
      end
    end
  end
endmodule

// [design/fcs_sequencer.sv]
// Operation
// - Stable supplies and restart high: pull READY, DONE low, then initialize.
// - After init raise READY and latch boot mode to pick the source.
// - Load and check data, wake fabric, raise DONE, then user mode.
// - Restart input has an internal pull-up, so floating reads inactive.
// - General-purpose pins stay high impedance until wake-up completes.
// - Port reads identifier, user word, status, and loads configuration memory.
// - Identifier verified first; only a matching device gets configured.
// - Status register records state before and after configuration.
// - Secured image refuses readback and verification.
// - Newer revisions keep running during flash programming; restart applies image.
// - Three-bit boot mode selects the start-up configuration mode.
// - Unbonded boot-mode bits read as zero.
// - READY and DONE carry no meaning during JTAG configuration.
// - Restart falling edge drops READY within 70 ns, DONE within 80 ns; here both drop on the third clock edge after it.
// - READY rises within 200 us of power, or 23 ms on volatile parts; here a few cycles after 200 us with the 200 us wait.
// - Power-up wait is 200 us with boot lsb 0, 50 us with 1.
`timescale 1ns/1ps
module fcs_sequencer #(
  parameter int INIT_LONG_CYC = fcs_pkg::WAIT_LONG_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Power and restart pins
  input  wire logic        supply_stable,
  input  wire logic        restart_config_n,
  output logic             restart_pullup_en,
  // Boot mode pins
  input  wire logic [2:0]  boot_mode_pin,
  input  wire logic [2:0]  boot_mode_bonded,
  // Indicators and fabric
  output logic             ready_out,
  output logic             done_out,
  output logic             user_mode,
  output logic             gpio_release,
  // Configuration source
  output logic [2:0]       cfg_mode,
  output logic             cfg_from_jtag,
  input  wire logic [7:0]  cfg_data,
  input  wire logic        cfg_valid,
  input  wire logic        cfg_last,
  output logic             cfg_ready,
  // Host command port
  input  wire logic        jtag_active,
  input  wire logic        flash_prog_active,
  input  wire logic [31:0] user_code,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_op,
  output logic             rsp_valid,
  output logic             rsp_refused,
  output logic [31:0]      rsp_data
);
  import fcs_pkg::*;

  fcs_ld_if   lk ();
  fcs_state_e st_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] init_len_q;
  logic [1:0] stable_s;
  logic [1:0] rst_s;
  logic [2:0] mode_s0;
  logic [2:0] mode_s1;
  logic       rst_prev_q;
  logic       restart_fall;
  logic       start_q;
  logic       id_fail_q;
  logic       chk_fail_q;
  logic       load_req;
  logic [31:0] status_w;

  fcs_loader u_loader (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .lk        (lk.ld),
    .cfg_data  (cfg_data),
    .cfg_valid (cfg_valid),
    .cfg_last  (cfg_last),
    .cfg_ready (cfg_ready)
  );

  // Pin synchronisers; first stages feed only second stages
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stable_s <= 2'h0;
      rst_s    <= 2'h3;
      mode_s0  <= 3'h0;
      mode_s1  <= 3'h0;
    end else begin
      stable_s <= {stable_s[0], supply_stable};
      rst_s    <= {rst_s[0], restart_config_n};
      mode_s0  <= boot_mode_pin;
      mode_s1  <= mode_s0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_prev_q <= 1'b1;
    end else begin
      rst_prev_q <= rst_s[1];
    end
  end

  assign restart_fall = rst_prev_q && !rst_s[1];
  assign load_req     = cmd_valid && jtag_active && cmd_op == OP_LOAD;
  assign lk.start     = start_q;
  // Supply loss must also free the loader, else the next start is ignored
  assign lk.abort     = restart_fall || !stable_s[1];

  // Weak pull to inactive level is on from the first cycle after reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      restart_pullup_en <= 1'b0;
    end else begin
      restart_pullup_en <= 1'b1;
    end
  end

  // Sequencer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q          <= FCS_OFF;
      cnt_q         <= '0;
      init_len_q    <= '0;
      start_q       <= 1'b0;
      cfg_mode      <= 3'h0;
      cfg_from_jtag <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (restart_fall || !stable_s[1]) begin
        // Abort anything, including user mode, and restart
        st_q <= FCS_OFF;
      end else if (load_req) begin
        // Configuration memory load requested over the host port
        st_q          <= FCS_LOAD;
        cfg_from_jtag <= 1'b1;
        start_q       <= 1'b1;
      end else begin
        case (st_q)
          FCS_OFF: begin
            // Wait for stable supply and released restart
            if (rst_s[1]) begin
              st_q  <= FCS_INIT;
              cnt_q <= '0;
              // Wait length from boot lsb, unbonded lsb reads zero
              init_len_q <= (mode_s1[0] & boot_mode_bonded[0]) ?
                            CNT_W'(WAIT_SHORT_CYC) : CNT_W'(INIT_LONG_CYC);
            end
          end
          FCS_INIT: begin
            // Bounded wait; with the 200 us wait READY rises a few cycles past the 200 us power-up limit
            if (cnt_q >= init_len_q - CNT_W'(1)) begin
              st_q <= FCS_SAMPLE;
            end else begin
              cnt_q <= cnt_q + CNT_W'(1);
            end
          end
          FCS_SAMPLE: begin
            // Mode latched as READY rises
            cfg_mode      <= mode_s1 & boot_mode_bonded;
            cfg_from_jtag <= 1'b0;
            start_q       <= 1'b1;
            st_q          <= FCS_LOAD;
          end
          FCS_LOAD: begin
            if (lk.done) begin
              cnt_q <= '0;
              // Bad identifier or bad check blocks user mode
              st_q  <= (lk.id_ok && lk.chk_ok) ? FCS_WAKE : FCS_FAIL;
            end
          end
          FCS_WAKE: begin
            if (cnt_q >= WAKE_CYC - CNT_W'(1)) begin
              st_q <= FCS_USER;
            end else begin
              cnt_q <= cnt_q + CNT_W'(1);
            end
          end
          // Flash programming does not disturb user mode
          FCS_USER: st_q <= FCS_USER;
          FCS_FAIL: st_q <= FCS_FAIL;
          default:  st_q <= FCS_OFF;
        endcase
      end
    end
  end

  // Outputs follow state; drop one cycle after a synced restart edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ready_out    <= 1'b0;
      done_out     <= 1'b0;
      user_mode    <= 1'b0;
      gpio_release <= 1'b0;
    end else if (restart_fall || !stable_s[1]) begin
      ready_out    <= 1'b0;
      done_out     <= 1'b0;
      user_mode    <= 1'b0;
      gpio_release <= 1'b0;
    end else begin
      // JTAG loads leave the indicators low as a fixed value
      ready_out    <= !cfg_from_jtag && st_q != FCS_OFF && st_q != FCS_INIT;
      // DONE rises with the last wake cycle, user mode one cycle later
      done_out     <= !cfg_from_jtag && (st_q == FCS_USER ||
                      (st_q == FCS_WAKE && cnt_q >= WAKE_CYC - CNT_W'(1)));
      user_mode    <= st_q == FCS_USER;
      gpio_release <= st_q == FCS_USER;
    end
  end

  // Sticky outcome flags, cleared when a new load begins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      id_fail_q  <= 1'b0;
      chk_fail_q <= 1'b0;
    end else if (lk.done) begin
      id_fail_q  <= !lk.id_ok;
      chk_fail_q <= lk.id_ok && !lk.chk_ok;
    end else if (start_q) begin
      id_fail_q  <= 1'b0;
      chk_fail_q <= 1'b0;
    end
  end

  always_comb begin
    status_w                           = 32'h0000_0000;
    status_w[ST_READY]                 = ready_out;
    status_w[ST_DONE]                  = done_out;
    status_w[ST_USER]                  = user_mode;
    status_w[ST_ID_FAIL]               = id_fail_q;
    status_w[ST_CHK_FAIL]              = chk_fail_q;
    status_w[ST_SECURE]                = lk.secure;
    status_w[ST_JTAG]                  = cfg_from_jtag;
    status_w[ST_BUSY]                  = lk.busy;
    status_w[ST_MODE_LSB +: 3]         = cfg_mode;
  end

  // Host answers one cycle after the command; ignored without jtag_active
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rsp_valid   <= 1'b0;
      rsp_refused <= 1'b0;
      rsp_data    <= 32'h0000_0000;
    end else begin
      rsp_valid   <= cmd_valid && jtag_active;
      rsp_refused <= 1'b0;
      rsp_data    <= 32'h0000_0000;
      if (cmd_valid && jtag_active) begin
        case (cmd_op)
          OP_RD_ID:     rsp_data <= DEVICE_IDENTIFIER;
          OP_RD_USER:   rsp_data <= user_code;
          OP_RD_STATUS: rsp_data <= status_w;
          OP_READBACK: begin
            // Secured image never leaves the device
            if (lk.secure || !lk.chk_ok) begin
              rsp_refused <= 1'b1;
            end else begin
              rsp_data <= {24'h00_0000, lk.chk_val};
            end
          end
          OP_LOAD:      rsp_data <= 32'h0000_0000;
          default:      rsp_refused <= 1'b1;
        endcase
      end
    end
  end
endmodule

// [testbench/fcs_seq_checker.sv]
`timescale 1ns/1ps
module fcs_seq_checker #(
  parameter int INIT_LONG_CYC = 20
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        resetn,
  // Pins and indicators
  input wire logic        restart_config_n,
  input wire logic [2:0]  boot_mode_bonded,
  input wire logic        ready_out,
  input wire logic        done_out,
  input wire logic        user_mode,
  input wire logic        gpio_release,
  input wire logic [2:0]  cfg_mode,
  input wire logic        cfg_from_jtag,
  // Host commands
  input wire logic        jtag_active,
  input wire logic        cmd_valid,
  input wire logic [2:0]  cmd_op,
  input wire logic        rsp_valid,
  input wire logic        rsp_refused,
  input wire logic [31:0] rsp_data
);
  import fcs_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  ready_first_a: assert property ($rose(ready_out) |-> !done_out)
    else $error("done up before ready");
  mode_hold_a: assert property (ready_out && $past(ready_out) |-> $stable(cfg_mode))
    else $error("boot mode changed while ready");
  user_after_a: assert property ($rose(done_out) |=> user_mode && gpio_release)
    else $error("user mode late after done");
  pins_hiz_a: assert property (gpio_release |-> user_mode
    && (done_out || cfg_from_jtag))
    else $error("pins released before wake");
  // Indicators carry no meaning after a host port load
  user_done_a: assert property (user_mode && !cfg_from_jtag |-> done_out && ready_out)
    else $error("user mode without done");
  unbonded_bits_a: assert property ($rose(ready_out) |->
    (cfg_mode & ~boot_mode_bonded) == 3'h0)
    else $error("unbonded mode bit set");
  restart_drop_a: assert property ($fell(restart_config_n) |->
    ##[1:3] !ready_out && !done_out)
    else $error("indicators slow to drop");
  cmd_answer_a: assert property (cmd_valid && jtag_active |=> rsp_valid)
    else $error("command not answered");
  no_cmd_rsp_a: assert property (rsp_valid |-> $past(cmd_valid) && $past(jtag_active))
    else $error("answer without command");
  refuse_data_a: assert property (rsp_refused && $past(cmd_op) == OP_READBACK |-> rsp_valid
    && rsp_data == 32'h0)
    else $error("refused readback leaks data");

  cv_user: cover property ($rose(user_mode));
  cv_refuse: cover property (rsp_refused);
  cv_restart: cover property ($fell(restart_config_n) ##3 !ready_out);
endmodule

bind fcs_sequencer fcs_seq_checker #(.INIT_LONG_CYC(INIT_LONG_CYC)) u_chk (
  .core_clk(core_clk), .resetn(resetn), .restart_config_n(restart_config_n),
  .boot_mode_bonded(boot_mode_bonded), .ready_out(ready_out), .done_out(done_out),
  .user_mode(user_mode), .gpio_release(gpio_release), .cfg_mode(cfg_mode),
  .cfg_from_jtag(cfg_from_jtag),
  .jtag_active(jtag_active), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .rsp_valid(rsp_valid), .rsp_refused(rsp_refused), .rsp_data(rsp_data));

// [testbench/fcs_host_model.sv]
`timescale 1ns/1ps
module fcs_host_model (
  // Clock
  input  wire logic       core_clk,
  // Byte stream
  input  wire logic       cfg_ready,
  output logic [7:0]      cfg_data,
  output logic            cfg_valid,
  output logic            cfg_last,
  // Xor of image before checksum
  output logic [7:0]      img_sum
);
  import fcs_pkg::*;
  initial begin
    cfg_data  = 8'hA5;
    cfg_valid = 1'b0;
    cfg_last  = 1'b0;
    img_sum   = 8'h00;
  end
  // Identifier MSB first, flags, body, xor checksum
  task automatic send_image(input logic sec, input logic bad_id, input logic bad_chk);
    logic [7:0] img[$];
    int         n;
    img = {};
    for (int i = 0; i < 4; i++) begin
      img.push_back(DEVICE_IDENTIFIER[31-8*i -: 8]);
    end
    img[0] = img[0] ^ {7'h0, bad_id};
    img.push_back({7'h0, sec});
    img.push_back(8'h3C);
    img.push_back(8'hE1);
    img_sum = 8'h00;
    foreach (img[i]) img_sum = img_sum ^ img[i];
    img.push_back(img_sum ^ {7'h0, bad_chk});
    foreach (img[i]) begin
      @(negedge core_clk);
      cfg_data  = img[i];
      cfg_valid = 1'b1;
      cfg_last  = (i == img.size() - 1);
      n = 0;
      while (cfg_ready !== 1'b1 && n < 40) begin
        @(negedge core_clk);
        n++;
      end
      // Device stopped taking bytes, give up the image
      if (n == 40) break;
      @(posedge core_clk);
    end
    @(negedge core_clk);
    cfg_valid = 1'b0;
    cfg_last  = 1'b0;
    // No stale byte left on an idle stream
    cfg_data  = ~cfg_data;
  endtask
endmodule

// [testbench/fpga_config_startup_sequencer_tb.sv]
`timescale 1ns/1ps
module fpga_config_startup_sequencer_tb;
  import fcs_pkg::*;
  localparam int INIT_N = 20;
  logic        core_clk, resetn, supply_stable, restart_config_n, restart_pullup_en;
  logic [2:0]  boot_mode_pin, boot_mode_bonded, cfg_mode, cmd_op;
  logic        ready_out, done_out, user_mode, gpio_release, cfg_from_jtag;
  logic [7:0]  cfg_data, img_sum;
  logic        cfg_valid, cfg_last, cfg_ready, jtag_active, flash_prog_active;
  logic        cmd_valid, rsp_valid, rsp_refused;
  logic [31:0] user_code, rsp_data;
  int          fail_count, checks, cycles;

  fcs_sequencer #(.INIT_LONG_CYC(INIT_N)) uut (
    .core_clk(core_clk), .resetn(resetn), .supply_stable(supply_stable),
    .restart_config_n(restart_config_n), .restart_pullup_en(restart_pullup_en),
    .boot_mode_pin(boot_mode_pin), .boot_mode_bonded(boot_mode_bonded),
    .ready_out(ready_out), .done_out(done_out), .user_mode(user_mode),
    .gpio_release(gpio_release), .cfg_mode(cfg_mode), .cfg_from_jtag(cfg_from_jtag),
    .cfg_data(cfg_data), .cfg_valid(cfg_valid), .cfg_last(cfg_last), .cfg_ready(cfg_ready),
    .jtag_active(jtag_active), .flash_prog_active(flash_prog_active),
    .user_code(user_code), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .rsp_valid(rsp_valid),
    .rsp_refused(rsp_refused), .rsp_data(rsp_data));
  fcs_host_model host (
    .core_clk(core_clk), .cfg_ready(cfg_ready), .cfg_data(cfg_data),
    .cfg_valid(cfg_valid), .cfg_last(cfg_last), .img_sum(img_sum));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Ceiling well above the longest boot
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      fail_count++;
      wrap_up();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task cmd(input logic [2:0] op);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op    = op;
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask
  task wait_user;
    int n;
    n = 0;
    while (user_mode !== 1'b1 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  // Restart by pin or by supply drop, then count to READY
  task boot(input logic by_pin, input logic [2:0] pins, input logic [2:0] bonded,
            input int n_init);
    int n;
    @(negedge core_clk);
    boot_mode_pin    = pins;
    boot_mode_bonded = bonded;
    if (by_pin) restart_config_n = 1'b0;
    else supply_stable = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({ready_out, done_out, user_mode, gpio_release}, 0);
    restart_config_n = 1'b1;
    supply_stable    = 1'b1;
    n = 0;
    while (ready_out !== 1'b1 && n < n_init + 10) begin
      @(negedge core_clk);
      n++;
      chk({done_out, gpio_release}, 0);
    end
    chk(n >= n_init && n <= n_init + 6, 1);
    chk(cfg_mode, pins & bonded);
  endtask

  task t_reset;
    repeat (6) @(negedge core_clk);
    chk({restart_pullup_en, ready_out, done_out}, 0);
    resetn = 1'b1;
    @(negedge core_clk);
    chk(restart_pullup_en, 1);
  endtask
  task t_good;
    boot(1'b0, 3'b110, 3'b111, INIT_N);
    host.send_image(1'b0, 1'b0, 1'b0);
    wait_user();
    chk({ready_out, done_out, user_mode, gpio_release}, 4'hF);
    cmd(OP_RD_ID);
    chk(rsp_data, DEVICE_IDENTIFIER);
    cmd(OP_RD_USER);
    chk(rsp_data, user_code);
    cmd(OP_RD_STATUS);
    chk(rsp_data[10:0], {3'h6, 8'h07});
    cmd(OP_READBACK);
    chk(rsp_refused, 0);
    chk(rsp_data, {24'h0, img_sum});
    for (int op = 5; op < 8; op++) begin
      cmd(op[2:0]);
      chk({rsp_valid, rsp_refused}, 2'b11);
    end
    jtag_active = 1'b0;
    cmd(OP_RD_ID);
    chk(rsp_valid, 0);
    // Flash programmed over the host port only, restart held high
    // Newer revision modelled, so no memory clear beforehand
    jtag_active       = 1'b1;
    flash_prog_active = 1'b1;
    repeat (20) @(negedge core_clk);
    chk(user_mode, 1);
    flash_prog_active = 1'b0;
  endtask
  task t_secure;
    boot(1'b1, 3'b111, 3'b001, WAIT_SHORT_CYC);
    host.send_image(1'b1, 1'b0, 1'b0);
    wait_user();
    chk(user_mode, 1);
    cmd(OP_READBACK);
    chk({rsp_valid, rsp_refused}, 2'b11);
    chk(rsp_data, 32'h0);
    cmd(OP_RD_STATUS);
    chk(rsp_data[ST_SECURE], 1);
  endtask
  task t_bad_chk;
    boot(1'b1, 3'b010, 3'b111, INIT_N);
    host.send_image(1'b0, 1'b0, 1'b1);
    repeat (20) @(negedge core_clk);
    chk({done_out, user_mode, gpio_release}, 0);
    cmd(OP_RD_STATUS);
    chk(rsp_data[ST_CHK_FAIL], 1);
    cmd(OP_READBACK);
    chk(rsp_refused, 1);
  endtask
  task t_bad_id;
    boot(1'b1, 3'b000, 3'b111, INIT_N);
    host.send_image(1'b0, 1'b1, 1'b0);
    chk({cfg_ready, done_out, user_mode}, 0);
    cmd(OP_RD_STATUS);
    chk(rsp_data[ST_ID_FAIL], 1);
  endtask
  // Host port load from the failed state
  task t_jtag;
    cmd(OP_LOAD);
    chk({rsp_valid, rsp_refused}, 2'b10);
    host.send_image(1'b0, 1'b0, 1'b0);
    wait_user();
    chk({ready_out, done_out, user_mode, gpio_release, cfg_from_jtag}, 5'h07);
    cmd(OP_RD_STATUS);
    chk(rsp_data[ST_JTAG], 1);
  endtask

  initial begin
    resetn            = 1'b0;
    supply_stable     = 1'b0;
    restart_config_n  = 1'b1;
    boot_mode_pin     = 3'h0;
    boot_mode_bonded  = 3'h7;
    jtag_active       = 1'b1;
    flash_prog_active = 1'b0;
    user_code         = 32'hC0DE_1234;
    cmd_valid         = 1'b0;
    cmd_op            = 3'h0;
    fail_count        = 0;
    checks            = 0;
    cycles            = 0;
    t_reset();
    t_good();
    t_secure();
    t_bad_chk();
    t_bad_id();
    t_jtag();
    wrap_up();
  end
endmodule
